/* hdl/dos_pkg.sv */
// package: constants, register map and types for the digital output sequencer
package dos_pkg;

  // ------------------------------------------------------------------
  // register map (byte offsets on the ahb-lite bus)
  // ------------------------------------------------------------------
  localparam logic [7:0]  DOS_OFF_DIRECT   = 8'h00;  // direct pattern set
  localparam logic [7:0]  DOS_OFF_SETUP    = 8'h04;  // channel and pattern count
  localparam logic [7:0]  DOS_OFF_INTERVAL = 8'h08;  // step interval, 100 us units
  localparam logic [7:0]  DOS_OFF_START    = 8'h0c;  // step count and trigger, starts
  localparam logic [7:0]  DOS_OFF_STATUS   = 8'h10;  // sequencer state, read only
  localparam logic [7:0]  DOS_OFF_PAT_BASE = 8'h80;  // 32 pattern words 0x80..0xfc

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int DOS_SETUP_CNT_LSB   = 8;   // pattern count field in setup
  localparam int DOS_START_TRIG_BIT  = 16;  // trigger selector in start
  localparam int DOS_STAT_IDX_LSB    = 4;   // current index in status
  localparam int DOS_STAT_LINES_LSB  = 16;  // output lines in status

  // ------------------------------------------------------------------
  // protocol values
  // ------------------------------------------------------------------
  localparam logic [5:0]  DOS_CHAN_PORT1   = 6'h1f;    // channel 31
  localparam logic [5:0]  DOS_CHAN_PORT2   = 6'h20;    // channel 32
  localparam logic [5:0]  DOS_MAX_PATTERNS = 6'h20;    // 32 stored codes
  localparam logic [15:0] DOS_MAX_STEPS    = 16'h2fff; // 12287 steps
  localparam logic [15:0] DOS_STEPS_CONT   = 16'hffff; // -1, run forever
  localparam logic [3:0]  DOS_FIRST_HIGH   = 4'hc;     // codes 12..15 drive lines 5,6

  // ------------------------------------------------------------------
  // timing: interval unit is the smallest programmable interval
  // ------------------------------------------------------------------
  localparam int DOS_UNIT_NS    = 100000;  // 0.0001 s
  localparam int DOS_CLK_NS     = 25;      // 40 mhz
  localparam int DOS_UNIT_CYC_I = DOS_UNIT_NS / DOS_CLK_NS;
  localparam logic [11:0] DOS_UNIT_CYC = 12'(DOS_UNIT_CYC_I);
  localparam logic [27:0] DOS_MAX_UNITS = 28'd160000000;  // 16000 s

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {DOS_IDLE, DOS_ARMED, DOS_RUN} dos_fsm_t;

  typedef struct packed {
    dos_fsm_t         fsm;        // sequencer state
    logic             pend_wr;    // write data phase pending
    logic [7:0]       pend_addr;  // address of pending write
    logic [5:0]       lines;      // output line levels
    logic [5:0]       chan;       // accepted channel
    logic [5:0]       cnt;        // stored pattern count
    logic             valid;      // a good setup is held
    logic [31:0][3:0] pat;        // stored pattern codes
    logic [27:0]      interval;   // step interval in units
    logic [13:0]      steps_left; // steps still to output
    logic             cont;       // continuous playback
    logic [4:0]       idx;        // index of pattern on the lines
    logic [11:0]      pre;        // unit prescaler
    logic [27:0]      ivl_cnt;    // units elapsed in this step
    logic             btn_q;      // button level last cycle
    logic [31:0]      hrdata;     // read data for the data phase
    logic             hresp;      // bus response, always okay
  } dos_st_t;

endpackage : dos_pkg

/* hdl/dos_sequencer.sv */
// module: six-line digital output sequencer with ahb-lite register access
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: code 0-11 drives lines 1-4, 12-15 lines 5-6
// R2: command value alone sets every line state
// R3: direct set applies pattern and holds it
// R4: direct code zero turns all lines off
// R5: setup accepted only on this unit's channel
// R6: setup holds 1 to 32 pattern codes
// R7: host sends exactly the declared pattern count
// R8: step advances once per programmed interval
// R9: step count 1 to 12287, -1 runs forever
// R10: after last pattern wrap to first
// R11: stop after total programmed steps output
// R12: trigger 1 waits for start button press
// R13: trigger 0 starts playback immediately
// R14: host initialises, sets up, then starts
// R15: reset leaves lines off, sequencer idle
// R16: first pattern at start, then one interval apart
module dos_sequencer
  import dos_pkg::*;
#(
  parameter logic [5:0] PORT_CHANNEL = DOS_CHAN_PORT1  // channel this unit answers to
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        start_button,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             output_line_1,
  output logic             output_line_2,
  output logic             output_line_3,
  output logic             output_line_4,
  output logic             output_line_5,
  output logic             output_line_6
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // code to line levels; lines of the other group are driven inactive
  function automatic logic [5:0] dos_decode(input logic [3:0] code);
    logic [5:0] r;
    r = 6'h00;
    if (code < DOS_FIRST_HIGH)
      r[3:0] = code;                         // R1 R2
    else
      r[5:4] = code[1:0];                    // R1 R2
    return r;
  endfunction : dos_decode

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dos_st_t    st_q;      // every flop of the block
  dos_st_t    st_d;      // next value
  logic       addr_ok;   // address phase taken
  logic       btn_rise;  // start button pressed this cycle
  logic       emit;      // put pattern nidx on the lines
  logic [4:0] nidx;      // index to emit
  logic [15:0] steps_w;  // step count in a start write
  logic [5:0]  cnt_w;    // count in a setup write

  assign addr_ok  = hsel & htrans[1] & hready;
  assign btn_rise = start_button & ~st_q.btn_q;
  assign steps_w  = hwdata[15:0];
  assign cnt_w    = hwdata[DOS_SETUP_CNT_LSB +: 6];

  // outputs straight from flops, hreadyout tied high; bus never stalls
  assign hreadyout     = 1'b1;
  assign hresp         = st_q.hresp;
  assign hrdata        = st_q.hrdata;
  assign output_line_1 = st_q.lines[0];
  assign output_line_2 = st_q.lines[1];
  assign output_line_3 = st_q.lines[2];
  assign output_line_4 = st_q.lines[3];
  assign output_line_5 = st_q.lines[4];
  assign output_line_6 = st_q.lines[5];

  // ------------------------------------------------------------------
  // next state: sequencer, then bus writes, then pattern emit
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d       = st_q;
    emit       = 1'b0;
    nidx       = 5'h00;
    st_d.btn_q = start_button;
    st_d.hresp = 1'b0;

    // sequencer
    case (st_q.fsm)
      DOS_IDLE:
      begin
        // lines hold the last pattern
      end
      DOS_ARMED:
      begin
        if (btn_rise)                        // R12
        begin
          st_d.fsm     = DOS_RUN;
          st_d.pre     = 12'h000;
          st_d.ivl_cnt = 28'h0000000;
          emit         = 1'b1;
          nidx         = 5'h00;              // R16
        end
      end
      DOS_RUN:
      begin
        // prescaler makes one pulse per interval unit
        if (st_q.pre == DOS_UNIT_CYC - 12'h001)
        begin
          st_d.pre = 12'h000;
          // interval of zero is treated as one unit
          if (st_q.ivl_cnt + 28'h0000001 >= st_q.interval)   // R8
          begin
            st_d.ivl_cnt = 28'h0000000;
            emit         = 1'b1;
            // wrap at the stored count
            if ({1'b0, st_q.idx} + 6'h01 >= st_q.cnt)       // R10
              nidx = 5'h00;
            else
              nidx = st_q.idx + 5'h01;
          end
          else
            st_d.ivl_cnt = st_q.ivl_cnt + 28'h0000001;
        end
        else
          st_d.pre = st_q.pre + 12'h001;
      end
      default:
        st_d.fsm = DOS_IDLE;
    endcase

    // address phase: latch write, prepare read data
    st_d.pend_wr = addr_ok & hwrite;
    if (addr_ok)
      st_d.pend_addr = haddr[7:0];
    if (addr_ok & ~hwrite)
    begin
      st_d.hrdata = 32'h00000000;            // unmapped reads zero
      if (haddr[7])
        st_d.hrdata = {28'h0000000, st_q.pat[haddr[6:2]]};
      else
        case (haddr[7:0])
          DOS_OFF_DIRECT:
            st_d.hrdata = {26'h0000000, st_q.lines};
          DOS_OFF_SETUP:
            st_d.hrdata = {18'h00000, st_q.cnt, 2'h0, st_q.chan};
          DOS_OFF_INTERVAL:
            st_d.hrdata = {4'h0, st_q.interval};
          DOS_OFF_START:
            st_d.hrdata = {17'h00000, st_q.cont, st_q.steps_left};
          DOS_OFF_STATUS:
            st_d.hrdata = {10'h000, st_q.lines, 6'h00, st_q.valid, st_q.idx,
                           2'h0, st_q.fsm};
          default:
            st_d.hrdata = 32'h00000000;
        endcase
    end

    // data phase of a write; an accepted direct, setup or start write overrides a step in the same cycle
    if (st_q.pend_wr)
    begin
      if (st_q.pend_addr[7])
        st_d.pat[st_q.pend_addr[6:2]] = hwdata[3:0];
      else
        case (st_q.pend_addr)
          DOS_OFF_DIRECT:
          begin
            // direct set stops playback and holds the code
            st_d.fsm   = DOS_IDLE;
            emit       = 1'b0;
            st_d.lines = dos_decode(hwdata[3:0]);         // R3 R4
          end
          DOS_OFF_SETUP:
          begin
            // only this unit's channel and a legal count are taken
            if (hwdata[5:0] == PORT_CHANNEL &&
                cnt_w != 6'h00 && cnt_w <= DOS_MAX_PATTERNS)   // R5 R6
            begin
              st_d.chan  = hwdata[5:0];
              st_d.cnt   = cnt_w;
              st_d.valid = 1'b1;
              st_d.fsm   = DOS_IDLE;
              emit       = 1'b0;
            end
          end
          DOS_OFF_INTERVAL:
          begin
            // clipped to the longest legal interval
            if (hwdata[27:0] > DOS_MAX_UNITS)
              st_d.interval = DOS_MAX_UNITS;
            else
              st_d.interval = hwdata[27:0];
          end
          DOS_OFF_START:
          begin
            // start needs a held setup and a legal step count
            if (st_q.valid && (steps_w == DOS_STEPS_CONT ||
                (steps_w != 16'h0000 && steps_w <= DOS_MAX_STEPS)))   // R9 R15
            begin
              st_d.cont       = (steps_w == DOS_STEPS_CONT);          // R9
              st_d.steps_left = steps_w[13:0];
              st_d.pre        = 12'h000;
              st_d.ivl_cnt    = 28'h0000000;
              if (hwdata[DOS_START_TRIG_BIT])
              begin
                st_d.fsm = DOS_ARMED;                                 // R12
                emit     = 1'b0;
              end
              else
              begin
                st_d.fsm = DOS_RUN;                                   // R13
                emit     = 1'b1;
                nidx     = 5'h00;                                     // R16
              end
            end
          end
          default:
          begin
            // unmapped write ignored
          end
        endcase
    end

    // emit one step; finish when the last counted step is out
    if (emit)
    begin
      st_d.idx   = nidx;
      st_d.lines = dos_decode(st_d.pat[nidx]);
      if (!st_d.cont)
      begin
        st_d.steps_left = st_d.steps_left - 14'h0001;
        if (st_d.steps_left == 14'h0000)
          st_d.fsm = DOS_IDLE;                                        // R11
      end
    end
  end

  // ------------------------------------------------------------------
  // state register: reset leaves lines off and the sequencer idle
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q          <= '0;                   // R15
      st_q.fsm      <= DOS_IDLE;
      st_q.interval <= 28'h0000001;
    end
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_direct_applies: assert property ( // R3
    $past(st_q.pend_wr) && $past(st_q.pend_addr) == DOS_OFF_DIRECT
    |-> st_q.lines == dos_decode($past(hwdata[3:0])) && st_q.fsm == DOS_IDLE)
    else $error("direct set not applied");

  a_zero_clears: assert property ( // R4
    $past(st_q.pend_wr) && $past(st_q.pend_addr) == DOS_OFF_DIRECT &&
    $past(hwdata[3:0]) == 4'h0 |-> st_q.lines == 6'h00)
    else $error("code zero left a line on");

  a_group_split: assert property ( // R1 R2
    st_q.lines[5:4] != 2'b00 |-> st_q.lines[3:0] == 4'h0)
    else $error("both line groups active");

  a_hold_idle: assert property ( // R3
    st_q.fsm == DOS_IDLE && !st_q.pend_wr |=> $stable(st_q.lines))
    else $error("lines changed while idle");

  a_setup_chan: assert property ( // R5 R6
    st_q.valid |-> st_q.chan == PORT_CHANNEL &&
    st_q.cnt >= 6'h01 && st_q.cnt <= DOS_MAX_PATTERNS)
    else $error("bad setup held");

  a_wrap_index: assert property ( // R10
    st_q.fsm == DOS_RUN |-> {1'b0, st_q.idx} < st_q.cnt)
    else $error("index beyond stored count");

  a_step_timing: assert property ( // R8 R16
    st_q.fsm == DOS_RUN && !st_q.pend_wr && st_q.pre != DOS_UNIT_CYC - 12'h001
    |=> $stable(st_q.idx) && $stable(st_q.lines))
    else $error("step between interval units");

  a_button_wait: assert property ( // R12
    st_q.fsm == DOS_ARMED && !btn_rise && !st_q.pend_wr |=> st_q.fsm == DOS_ARMED)
    else $error("armed sequencer started without button");

  a_start_now: assert property ( // R13 R16
    st_q.pend_wr && st_q.pend_addr == DOS_OFF_START && st_q.valid &&
    !hwdata[DOS_START_TRIG_BIT] &&
    (steps_w == DOS_STEPS_CONT || (steps_w > 16'h0001 && steps_w <= DOS_MAX_STEPS))
    |=> st_q.fsm == DOS_RUN && st_q.idx == 5'h00 &&
        st_q.lines == dos_decode(st_q.pat[0]))
    else $error("immediate start did not emit first pattern");

  a_count_ends: assert property ( // R9 R11
    st_q.fsm != DOS_IDLE && !st_q.cont |-> st_q.steps_left != 14'h0000)
    else $error("running with no steps left");

  a_needs_setup: assert property ( // R15
    st_q.fsm != DOS_IDLE |-> st_q.valid)
    else $error("sequencer active without setup");

  // the checks below watch the sequencer's own steps only; a bus write in the
  // same cycle may override a step, so such cycles are left out on purpose

  // a single remaining step would send the sequencer straight back to idle
  a_arm_start: assert property ( // R12 R16
    st_q.fsm == DOS_ARMED && btn_rise && !st_q.pend_wr &&
    (st_q.cont || st_q.steps_left != 14'h0001)
    |=> st_q.fsm == DOS_RUN && st_q.idx == 5'h00 &&
        st_q.lines == dos_decode(st_q.pat[0]))
    else $error("button press did not emit first pattern");

  a_last_step: assert property ( // R11
    emit && !st_q.cont && st_q.steps_left == 14'h0001 && !st_q.pend_wr
    |=> st_q.fsm == DOS_IDLE)
    else $error("sequencer ran past its last step");

  a_cont_runs: assert property ( // R9
    emit && st_q.cont && !st_q.pend_wr |=> st_q.fsm == DOS_RUN)
    else $error("continuous playback stopped");

endmodule : dos_sequencer

`default_nettype wire

/* tb/dos_host_model.sv */
// host model: ahb-lite master that sends commands and reads status
`timescale 1ns/100ps
`default_nettype none

module dos_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // ------------------------------------------------------------------
  // idle bus from time zero
  // ------------------------------------------------------------------
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ------------------------------------------------------------------
  // one single word transfer, held until hready is seen high
  // ------------------------------------------------------------------
  // callers send the whole command word; the first start goes out before any setup on purpose
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    // data phase: write data on, address phase released
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    q = hrdata;
    // released data bus must not keep showing the last word
    hwdata <= ~d;
  endtask : xfer
endmodule : dos_host_model
`default_nettype wire

/* tb/dos_sequencer_tb.sv */
// testbench: direct and sequenced output checks through the register bus
`timescale 1ns/100ps
`default_nettype none

module dos_sequencer_tb;
  import dos_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        hclk, hresetn, start_button;  // clock, reset, manual button
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        output_line_1, output_line_2, output_line_3;
  logic        output_line_4, output_line_5, output_line_6;
  logic [5:0]  lines;                        // lines 6..1 gathered
  int          bad_count, cmp_count;
  localparam int LIMIT = 40000;               // whole run is near 20200 cycles

  assign lines = {output_line_6, output_line_5, output_line_4,
                  output_line_3, output_line_2, output_line_1};

  dos_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .start_button(start_button), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .output_line_1(output_line_1),
    .output_line_2(output_line_2), .output_line_3(output_line_3),
    .output_line_4(output_line_4), .output_line_5(output_line_5),
    .output_line_6(output_line_6));

  dos_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr

  // read one word and compare only the masked field
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdm

  // low codes light lines 1-4, high codes use bits 0,1 on lines 5,6
  function automatic logic [31:0] dec(input logic [3:0] c);
    return (c < 4'hc) ? {28'h0, c} : {26'h0, c[1:0], 4'h0};
  endfunction : dec

  // lines must hold for 3999 cycles and change on the 4000th
  task automatic step_to(input logic [5:0] p, input logic [5:0] n);
    repeat (3999) @(posedge hclk);
    #1 chk({26'h0, lines}, {26'h0, p});
    @(posedge hclk);
    #1 chk({26'h0, lines}, {26'h0, n});
  endtask : step_to

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial
  begin
    repeat (LIMIT) @(posedge hclk);
    bad_count++;
    give_verdict();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    hresetn      = 1'b0;
    start_button = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk({26'h0, lines}, 32'h0);
    rdm(DOS_OFF_STATUS, 32'h3ff, 32'h0);
    // wrong port, oversize count and a start without setup are all dropped
    wr(DOS_OFF_SETUP, 32'h0220);
    rdm(DOS_OFF_STATUS, 32'h200, 32'h0);
    wr(DOS_OFF_SETUP, 32'h211f);
    rdm(DOS_OFF_STATUS, 32'h200, 32'h0);
    wr(DOS_OFF_START, 32'h3);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h0);
    for (int c = 0; c < 17; c++)
    begin
      wr(DOS_OFF_DIRECT, 32'(c % 16));
      #1 chk({26'h0, lines}, dec(4'(c % 16)));
    end
    // two patterns, one unit, three steps, immediate start
    wr(DOS_OFF_PAT_BASE, 32'h7);
    wr(DOS_OFF_PAT_BASE + 8'h4, 32'h0);
    wr(DOS_OFF_INTERVAL, 32'h1);
    wr(DOS_OFF_SETUP, 32'h021f);
    rdm(DOS_OFF_STATUS, 32'h200, 32'h200);
    wr(DOS_OFF_START, 32'h3);
    #1 chk({26'h0, lines}, 32'h7);
    step_to(6'h07, 6'h00);
    step_to(6'h00, 6'h07);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h0);
    // step counts 0 and 12288 are refused, the top value 12287 arms
    wr(DOS_OFF_START, 32'h0);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h0);
    wr(DOS_OFF_START, 32'h3000);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h0);
    wr(DOS_OFF_START, 32'h12fff);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h1);
    rdm(DOS_OFF_START, 32'h7fff, 32'h2fff);
    // three high codes, continuous, waiting for the button
    wr(DOS_OFF_PAT_BASE, 32'hc);
    wr(DOS_OFF_PAT_BASE + 8'h4, 32'hd);
    wr(DOS_OFF_PAT_BASE + 8'h8, 32'hf);
    wr(DOS_OFF_SETUP, 32'h031f);
    wr(DOS_OFF_START, 32'h1ffff);
    repeat (20) @(posedge hclk);
    #1 chk({26'h0, lines}, 32'h7);
    @(posedge hclk) start_button <= 1'b1;
    @(posedge hclk) start_button <= 1'b0;
    #1 chk({26'h0, lines}, 32'h0);
    step_to(6'h00, 6'h10);
    step_to(6'h10, 6'h30);
    step_to(6'h30, 6'h00);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h2);
    rdm(DOS_OFF_START, 32'h4000, 32'h4000);
    // a direct command ends playback and holds its own pattern
    wr(DOS_OFF_DIRECT, 32'h5);
    #1 chk({26'h0, lines}, 32'h5);
    rdm(DOS_OFF_STATUS, 32'h3, 32'h0);
    give_verdict();
  end
endmodule : dos_sequencer_tb
`default_nettype wire
